//--- logic/acsr_pkg.sv
// Package: constants and types for the conversion cycle and serial readout block
// ==================================================================
// Overview of operation
// [R1] Cycle runs conversion, then sleep, then data output, then converts again.
// [R2] Finished conversion moves to sleep with no host action.
// [R3] Sleep with chip select high holds the result unchanged indefinitely.
// [R4] Chip select low enters output; high before first rise returns to sleep.
// [R5] After first rise, output proceeds; early chip select high aborts and reconverts.
// [R6] Data changes on serial clock falling edges; host samples on rising edges. Pin lags each fall by a core clock; host model samples late in high phase.
// [R7] Frame is 24 bits: three status, 17-bit result MSB first, four zeros.
// [R8] Clock edges past the 24th leave conversion alone and read as ones.
// [R9] Bit 23 is pending flag, high converting, low when done, shown whenever selected.
// [R10] Bit 22 filler bit is always low.
// [R11] Bit 21 polarity bit is high for non-negative input, low for negative.
// [R12] Bits 21 and 20 both high flag overrange, both low flag underrange.
// [R13] Bits 20 to 4 carry signed result; bits 3 to 0 are low.
// [R14] Chip select high: data output floats and serial clock is ignored.
// [R15] With chip select low, pending level falls when conversion completes.
// [R16] Bit 22 leaves on first falling edge, bit 0 on the 23rd.
// [R17] 24th falling edge drives output high, marking a new conversion.
// [R18] Out-of-range results clamp to plus full scale plus one, minus full scale minus one.
// [R19] Modes come only from chip select and clock timing; no configuration registers.
// [R20] Clock mode sampled at reset release or chip select fall; internal mode drives clock. Reset release reads sck_q at its reset value, not the pin.
// [R21] After reset, an internal reset of about 4 ms precedes the first conversion.
// [R22] Conversion length is a configurable count of conversion clock cycles.
package acsr_pkg;
  // ==================================================================
  // Frame layout
  localparam int FRAME_BITS      = 24;
  localparam int RESULT_BITS     = 17;
  localparam int PEND_POS        = 23;
  localparam int FILLER_POS      = 22;
  localparam int POLARITY_POS    = 21;
  localparam int RESULT_MSB_POS  = 20;
  localparam int RESULT_LSB_POS  = 4;
  localparam logic [16:0] RES_POS_CLAMP = 17'h10000; // +FS+1LSB with polarity high
  localparam logic [16:0] RES_NEG_CLAMP = 17'h0ffff; // -FS-1LSB with polarity low
  localparam logic [4:0]  LAST_FALL     = 5'h18;
  // ==================================================================
  // Timing
  localparam int CLK_HZ         = 40000000;
  localparam int POR_US         = 4000;
  localparam int POR_CYCLES     = POR_US * (CLK_HZ / 1000000);
  localparam int CONV_CYCLES    = 41036;
  localparam int ISCK_HALF      = 16;
  typedef enum logic [1:0] {ACSR_POR, ACSR_CONVERT, ACSR_SLEEP, ACSR_OUTPUT} acsr_state_e;
  typedef struct packed {
    logic        polarity_bit;
    logic [16:0] result;
  } acsr_sample_s;
endpackage

//--- logic/acsr_top.sv
// Conversion-cycle state machine with 3-wire serial readout
`timescale 1ns/10ps
module acsr_top #(
  parameter int POR_CYC  = acsr_pkg::POR_CYCLES,  // Internal reset length
  parameter int CONV_CYC = acsr_pkg::CONV_CYCLES  // Conversion length in clk cycles
) (
  input  wire logic               clk,           // 40 MHz core clock
  input  wire logic               rst_n,         // Async reset, active low
  input  wire logic               sck_clk,       // Serial clock as seen at the pin
  input  wire logic               cs_n,          // Chip select, active low
  input  wire logic               sck_i,         // Serial clock pin level
  input  wire acsr_pkg::acsr_sample_s sample,    // Modulator result, stable
  input  wire logic               sample_ovr,    // Input above +FS
  input  wire logic               sample_und,    // Input below -FS
  output logic                    sdo_o,         // Serial data out
  output logic                    sdo_oe_n,      // Data output enable, low drives
  output logic                    sck_o,         // Internal serial clock out
  output logic                    sck_oe_n,      // Clock output enable, low drives
  output logic                    busy_r         // Internal reset or conversion in progress
);
  // ==================================================================
  // Synchronisers into clk domain
  logic [1:0] cs_s, sck_s, fall_t_s;
  logic       cs_q, sck_q, fall_q;
  logic       fall_tog_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s     <= 2'h3;
      sck_s    <= 2'h0;
      fall_t_s <= 2'h0;
      cs_q     <= 1'b1;
      fall_q   <= 1'b0;
      sck_q    <= 1'b0;
    end else begin
      cs_s     <= {cs_s[0], cs_n};
      sck_s    <= {sck_s[0], sck_i};
      fall_t_s <= {fall_t_s[0], fall_tog_r};
      cs_q     <= cs_s[1];
      fall_q   <= fall_t_s[1];
      sck_q    <= sck_s[1];
    end
  end
  wire cs_low  = !cs_s[1];
  wire cs_fall = cs_q && !cs_s[1];
  wire cs_rise = !cs_q && cs_s[1];
  wire done_ev = fall_q != fall_t_s[1];   // 24th falling edge seen

  // ==================================================================
  // Cycle state machine
  acsr_pkg::acsr_state_e st_r;
  logic [31:0] cnt_r;
  logic        rose_r;     // Set from link: first rising edge seen
  logic [1:0]  rose_s;
  logic        started_r;  // First rise seen during this output state
  logic        out_en_r;   // Output state, held steady across a frame
  logic        int_mode_r;
  logic [16:0] res_r;
  logic        pol_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r  <= acsr_pkg::ACSR_POR;
      cnt_r <= 32'h0;
    end else begin
      case (st_r)
        acsr_pkg::ACSR_POR: begin
          if (cnt_r >= 32'(POR_CYC - 1)) begin // R21
            st_r  <= acsr_pkg::ACSR_CONVERT;
            cnt_r <= 32'h0;
          end else cnt_r <= cnt_r + 32'h1;
        end
        acsr_pkg::ACSR_CONVERT: begin
          if (cnt_r >= 32'(CONV_CYC - 1)) begin // R22
            st_r  <= acsr_pkg::ACSR_SLEEP;       // R2
            cnt_r <= 32'h0;
          end else cnt_r <= cnt_r + 32'h1;
        end
        acsr_pkg::ACSR_SLEEP: begin
          if (cs_low) st_r <= acsr_pkg::ACSR_OUTPUT; // R4
        end
        acsr_pkg::ACSR_OUTPUT: begin
          if (done_ev || (cs_rise && started_r)) begin
            st_r <= acsr_pkg::ACSR_CONVERT;       // R1 R5
          end else if (cs_rise) begin
            st_r <= acsr_pkg::ACSR_SLEEP;         // R4
          end
        end
        default: st_r <= acsr_pkg::ACSR_POR;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busy_r <= 1'b1;
    else busy_r <= (st_r != acsr_pkg::ACSR_SLEEP) && (st_r != acsr_pkg::ACSR_OUTPUT);
  end

  // Link flag is cleared by chip select before its rise reaches this domain,
  // so the first rise is remembered here until the output state ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) started_r <= 1'b0;
    else if (st_r != acsr_pkg::ACSR_OUTPUT) started_r <= 1'b0;
    else if (rose_s[1]) started_r <= 1'b1; // R5
  end

  // Quasi-static enable for the link: it settles several core clocks
  // before the host may raise the first serial clock edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) out_en_r <= 1'b0;
    else out_en_r <= (st_r == acsr_pkg::ACSR_OUTPUT);
  end

  // Result latched once at end of conversion, held through sleep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_r <= 17'h0;
      pol_r <= 1'b0;
    end else if (st_r == acsr_pkg::ACSR_CONVERT && cnt_r >= 32'(CONV_CYC - 1)) begin
      pol_r <= sample.polarity_bit; // R11
      if (sample_ovr) begin
        res_r <= acsr_pkg::RES_POS_CLAMP; // R18 R12
        pol_r <= 1'b1;
      end else if (sample_und) begin
        res_r <= acsr_pkg::RES_NEG_CLAMP; // R18 R12
        pol_r <= 1'b0;
      end else res_r <= sample.result;    // R13
    end
  end

  // Clock mode set to internal after reset release (sck_q still at its reset value), caught from the pin on each chip select fall
  logic mode_init_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_mode_r  <= 1'b0;
      mode_init_r <= 1'b0;
    end else begin
      mode_init_r <= 1'b1;
      if (!mode_init_r || cs_fall) int_mode_r <= !sck_q; // R20
    end
  end

  // Internal serial clock: 24 periods, only in output state
  logic [3:0] div_r;
  logic [5:0] iedge_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r   <= 4'h0;
      iedge_r <= 6'h0;
      sck_o   <= 1'b0;
    end else if (int_mode_r && st_r == acsr_pkg::ACSR_OUTPUT && iedge_r < 6'd48) begin
      div_r <= div_r + 4'h1;
      if (div_r == 4'(acsr_pkg::ISCK_HALF - 1)) begin
        sck_o   <= !sck_o; // R20
        iedge_r <= iedge_r + 6'h1;
      end
    end else begin
      div_r   <= 4'h0;
      sck_o   <= 1'b0;
      if (st_r != acsr_pkg::ACSR_OUTPUT) iedge_r <= 6'h0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sck_oe_n <= 1'b1;
    else sck_oe_n <= !(int_mode_r && cs_low);
  end

  // ==================================================================
  // Link domain: shift register on serial clock
  logic [23:0] frame;
  logic [4:0]  fall_cnt_r;
  logic        sdo_r;
  logic        link_clr_n;
  assign frame = {1'b0, 1'b0, pol_r, res_r, 4'h0}; // R7 R10 R13
  // Shift logic is held clear while deselected, so stray clocks do nothing
  assign link_clr_n = rst_n && !cs_n; // R14
  // First rise: cleared when chip select goes high
  always_ff @(posedge sck_clk or posedge cs_n) begin
    if (cs_n) rose_r <= 1'b0;
    else if (out_en_r) rose_r <= 1'b1; // R5
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rose_s <= 2'h0;
    else rose_s <= {rose_s[0], rose_r};
  end
  // Cleared value is the low pending bit of a finished result
  always_ff @(negedge sck_clk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      fall_cnt_r <= 5'h0;
      sdo_r      <= 1'b0;
    end else if (!out_en_r) begin
      fall_cnt_r <= 5'h0;
      sdo_r      <= 1'b0;
    end else if (fall_cnt_r < acsr_pkg::LAST_FALL) begin
      fall_cnt_r <= fall_cnt_r + 5'h1;             // R6 R16
      if (fall_cnt_r == acsr_pkg::LAST_FALL - 5'h1) sdo_r <= 1'b1; // R17
      else sdo_r <= frame[5'd22 - fall_cnt_r];
    end else sdo_r <= 1'b1;                       // R8
  end
  // Frame end toggles; the core side sees it through two flops
  always_ff @(negedge sck_clk or negedge rst_n) begin
    if (!rst_n) fall_tog_r <= 1'b0;
    else if (out_en_r && fall_cnt_r == acsr_pkg::LAST_FALL - 5'h1) fall_tog_r <= !fall_tog_r; // R17
  end

  // Output pin: pending flag outside output, shifted data inside it.
  // Data bit is single and is taken on the next core clock edge after each fall.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_o    <= 1'b1;
      sdo_oe_n <= 1'b1;
    end else begin
      sdo_oe_n <= !cs_low;                        // R14
      if (st_r == acsr_pkg::ACSR_OUTPUT) sdo_o <= sdo_r;
      else sdo_o <= (st_r != acsr_pkg::ACSR_SLEEP); // R9 R15
    end
  end
  // R19: no configuration registers exist; mode is pin timing only

  // ==================================================================
  // Assertions
  AST_SLEEP_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // R3
    st_r == acsr_pkg::ACSR_SLEEP && $stable(st_r) |-> $stable(res_r))
    else $error("result changed in sleep");
  AST_CONV_TO_SLEEP: assert property (@(posedge clk) disable iff (!rst_n) // R2
    st_r == acsr_pkg::ACSR_CONVERT ##1 st_r != acsr_pkg::ACSR_CONVERT |-> st_r == acsr_pkg::ACSR_SLEEP)
    else $error("conversion did not end in sleep");
  AST_SLEEP_EXIT: assert property (@(posedge clk) disable iff (!rst_n) // R1
    st_r == acsr_pkg::ACSR_SLEEP ##1 st_r != acsr_pkg::ACSR_SLEEP |-> st_r == acsr_pkg::ACSR_OUTPUT)
    else $error("sleep left to wrong state");
  AST_HIZ: assert property (@(posedge clk) disable iff (!rst_n) // R14
    cs_s[1] ##1 cs_s[1] |-> sdo_oe_n)
    else $error("data driven while deselected");
  AST_PENDING: assert property (@(posedge clk) disable iff (!rst_n) // R9
    st_r == acsr_pkg::ACSR_CONVERT |=> sdo_o)
    else $error("pending flag low during conversion");
  AST_SLEEP_LOW: assert property (@(posedge clk) disable iff (!rst_n) // R15
    st_r == acsr_pkg::ACSR_SLEEP |=> !sdo_o)
    else $error("pending flag high after completion");
  AST_OVR_CLAMP: assert property (@(posedge clk) disable iff (!rst_n) // R18
    st_r == acsr_pkg::ACSR_CONVERT && cnt_r >= 32'(CONV_CYC - 1) && sample_ovr
      |=> res_r == acsr_pkg::RES_POS_CLAMP && pol_r)
    else $error("overrange not clamped");
  AST_UND_CLAMP: assert property (@(posedge clk) disable iff (!rst_n) // R12
    st_r == acsr_pkg::ACSR_CONVERT && cnt_r >= 32'(CONV_CYC - 1) && !sample_ovr && sample_und
      |=> res_r == acsr_pkg::RES_NEG_CLAMP && !pol_r)
    else $error("underrange not clamped");

  AST_ABORT: assert property (@(posedge clk) disable iff (!rst_n) // R5
    st_r == acsr_pkg::ACSR_OUTPUT && cs_rise && started_r |=> st_r == acsr_pkg::ACSR_CONVERT)
    else $error("abort did not restart conversion");

  AST_PEEK: assert property (@(posedge clk) disable iff (!rst_n) // R4
    st_r == acsr_pkg::ACSR_OUTPUT && cs_rise && !started_r && !done_ev |=> st_r == acsr_pkg::ACSR_SLEEP)
    else $error("peek did not return to sleep");

  AST_FRAME_END: assert property (@(posedge clk) disable iff (!rst_n) // R17
    st_r == acsr_pkg::ACSR_OUTPUT && done_ev |=> st_r == acsr_pkg::ACSR_CONVERT ##1 busy_r)
    else $error("frame end did not start conversion");

  AST_ENTER_OUT: assert property (@(posedge clk) disable iff (!rst_n) // R4
    st_r == acsr_pkg::ACSR_SLEEP && cs_low |=> st_r == acsr_pkg::ACSR_OUTPUT)
    else $error("select did not enter output");
endmodule

//--- verification/acsr_host.sv
// Host-side serial master model: chip select, serial clock and capture
`timescale 1ns/10ps
module acsr_host (
  input  wire logic        clk,   // Core clock, paces chip select
  input  wire logic        sdo,   // Resolved data line
  output logic             cs_n,  // Chip select, active low
  output logic             sck,   // Serial clock, still low outside frames
  output logic [31:0]      rx     // Captured bits, first bit highest
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    rx   = 32'h0;
  end
  // ==================================================================
  // Framing
  task automatic select();
    @(negedge clk);
    cs_n = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic deselect();
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  // Sampled late in the high phase: the output lags each fall by a core clock
  task automatic clocks(input int n);
    rx = 32'h0;
    repeat (n) begin
      #16 sck = 1'b1;
      #15 rx = {rx[30:0], sdo};
      #1 sck = 1'b0;
    end
  endtask
endmodule

//--- verification/test_adc_cycle_serial_readout.sv
// Self-checking bench for the conversion cycle and serial readout block
`timescale 1ns/10ps
module test_adc_cycle_serial_readout;
  typedef struct {
    logic [17:0] s;
    logic        ovr;
    logic        und;
    logic [23:0] exp;
  } acsr_row_s;
  logic                   clk;
  logic                   rst_n;
  logic                   cs_n;
  logic                   sck;
  logic                   sdo_o;
  logic                   sdo_oe_n;
  logic                   busy_r;
  logic                   sck_pin;
  logic                   sck_o_w;
  logic                   sck_oe_n_w;
  logic                   sample_ovr;
  logic                   sample_und;
  acsr_pkg::acsr_sample_s sample;
  logic [31:0]            rx;
  wire                    sdo = sdo_oe_n ? 1'bz : sdo_o;
  int                     fails;
  int                     check_count;
  acsr_row_s rows [4] = '{
    '{18'h2abcd, 1'b0, 1'b0, {3'b001, 17'h0abcd, 4'h0}},
    '{18'h1fff1, 1'b0, 1'b0, {3'b000, 17'h1fff1, 4'h0}},
    '{18'h20005, 1'b1, 1'b0, {3'b001, 17'h10000, 4'h0}},
    '{18'h00007, 1'b0, 1'b1, {3'b000, 17'h0ffff, 4'h0}}};
  // ==================================================================
  // Instances
  acsr_top #(.POR_CYC(20), .CONV_CYC(200)) u_acsr_top (
    .clk(clk), .rst_n(rst_n), .sck_clk(sck), .cs_n(cs_n),
    .sck_i(sck_pin),
    .sample(sample), .sample_ovr(sample_ovr), .sample_und(sample_und),
    .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .sck_o(sck_o_w), .sck_oe_n(sck_oe_n_w), .busy_r(busy_r));
  acsr_host u_acsr_host (.clk(clk), .sdo(sdo), .cs_n(cs_n), .sck(sck), .rx(rx));
  always #12.5 clk = ~clk;
  // ==================================================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wait_busy(input logic v);
    int i;
    for (i = 0; i < 2000 && busy_r !== v; i++) @(negedge clk);
    if (busy_r !== v) begin
      fails++;
      $display("Error at %0t: busy wait ran out", $time);
      report_and_stop();
    end
  endtask
  // ==================================================================
  // Sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    sck_pin = 1'b1;
    fails = 0;
    check_count = 0;
    sample = rows[0].s;
    sample_ovr = 1'b0;
    sample_und = 1'b0;
    repeat (8) @(negedge clk);
    check(busy_r, 1'b1);
    check(sdo_oe_n, 1'b1);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      @(negedge clk);
      sample = rows[i].s;
      sample_ovr = rows[i].ovr;
      sample_und = rows[i].und;
      wait_busy(1'b0);
      u_acsr_host.select();
      u_acsr_host.clocks(24);
      check(rx, {8'h0, rows[i].exp});
      u_acsr_host.deselect();
      check(busy_r, 1'b1);
      check(sdo_oe_n, 1'b1);
    end
    // Host issuing 32 clocks
    sample = rows[0].s;
    sample_ovr = 1'b0;
    sample_und = 1'b0;
    wait_busy(1'b0);
    u_acsr_host.select();
    u_acsr_host.clocks(32);
    check(rx, {rows[0].exp, 8'hff});
    u_acsr_host.deselect();
    check(busy_r, 1'b1);
    wait_busy(1'b0);
    // Peek without clocks, then long sleep, then the held result
    u_acsr_host.select();
    u_acsr_host.deselect();
    check(busy_r, 1'b0);
    repeat (300) @(negedge clk);
    check(busy_r, 1'b0);
    u_acsr_host.select();
    u_acsr_host.clocks(24);
    check(rx, {8'h0, rows[0].exp});
    u_acsr_host.deselect();
    // Selected during conversion: pending level and its fall
    u_acsr_host.select();
    check(sdo, 1'b1);
    check(sck_oe_n_w, 1'b1);
    check(sck_o_w, 1'b0);
    wait_busy(1'b0);
    repeat (3) @(negedge clk);
    check(sdo, 1'b0);
    u_acsr_host.deselect();
    check(busy_r, 1'b0);
    // Abort after a few clocks restarts conversion
    u_acsr_host.select();
    u_acsr_host.clocks(5);
    u_acsr_host.deselect();
    check(busy_r, 1'b1);
    wait_busy(1'b0);
    report_and_stop();
  end
endmodule
